// File: core/rst_strobe_pkg.sv
package rst_strobe_pkg;

    // =========================================================
    // Timing
    // =========================================================
    localparam int REF_CLK_MHZ        = 40;
    // Reset release to first command, in microseconds.
    localparam int RESET_TO_CMD_US    = 200;
    // Least time, so rounded up; a whole number at this rate.
    localparam int RESET_TO_CMD_CYC   = RESET_TO_CMD_US * REF_CLK_MHZ;

    // =========================================================
    // Reset-enable configuration field
    // =========================================================
    localparam int          RST_FIELD_W     = 2;
    localparam logic [1:0]  RST_FIELD_RESET = 2'h0;
    // Only this code lets the hardware reset input act.
    localparam logic [1:0]  RST_FIELD_ON    = 2'h1;

    // =========================================================
    // Carriers
    // =========================================================
    typedef struct packed {
        logic cmd_resp;
        logic read_data;
        logic crc_token;
    } strobe_src_t;

    typedef struct packed {
        logic                   valid;
        logic [RST_FIELD_W-1:0] rst_field;
    } rst_cfg_t;

    typedef enum logic [2:0] {
        ST_WAIT_CFG = 3'h1,
        ST_READY    = 3'h2,
        ST_SEQ      = 3'h4
    } seq_state_t;

endpackage : rst_strobe_pkg

// File: core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Pin side and synchronised level
    input  wire logic pin_in,
    output logic      pin_sync_out
);

    logic meta_reg;
    logic sync_reg;

    // =========================================================
    // Two-stage synchroniser
    // =========================================================
    // The first stage feeds only the second, so no logic ever
    // sees a metastable value.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    assign pin_sync_out = sync_reg;

endmodule : pin_sync

// File: core/hw_reset_and_strobe_control.sv
// Functional notes
// - In double-rate mode the strobe toggles with every command response.
// - Otherwise strobe never toggles; it stays low with its output disabled.
// - Internal reset sequence starts on reset pin rising edge, not falling.
// - Before reset-enable field is loaded, reset input may be ignored.
`timescale 1ns/1ps
module hw_reset_and_strobe_control #(
    parameter int SEQ_CYCLES = rst_strobe_pkg::RESET_TO_CMD_CYC
) (
    // Clock and power-on reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst_b,
    // Hardware reset pin from the host
    input  wire logic                        hw_reset_pin_b,
    // Configuration load from the controller
    input  wire rst_strobe_pkg::rst_cfg_t    cfg_load,
    // Bus mode and strobe sources
    input  wire logic                        ddr_mode,
    input  wire rst_strobe_pkg::strobe_src_t strobe_src,
    // Strobe pin
    output logic                             read_strobe_pin,
    output logic                             read_strobe_oe,
    // Reset sequence status
    output logic                             cfg_loaded,
    output logic                             seq_start,
    output logic                             core_reset_b
);

    localparam int CNT_W = (SEQ_CYCLES > 1) ? $clog2(SEQ_CYCLES + 1) : 1;

    generate
        if (SEQ_CYCLES < 1) begin : g_bad_seq
            $error("SEQ_CYCLES must be at least one");
        end
    endgenerate

    // =========================================================
    // Reset pin synchronisation and edge detection
    // =========================================================
    logic pin_lvl;
    logic pin_prev_reg;
    wire  pin_rise;
    wire  pin_fall;

    pin_sync #(
        .RESET_VAL (1'b1)
    ) u_pin_sync (
        .ref_clk      (ref_clk),
        .rst_b        (rst_b),
        .pin_in       (hw_reset_pin_b),
        .pin_sync_out (pin_lvl)
    );

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_prev_reg <= 1'b1;
        end else begin
            pin_prev_reg <= pin_lvl;
        end
    end

    assign pin_rise = pin_lvl & ~pin_prev_reg;
    assign pin_fall = ~pin_lvl & pin_prev_reg;

    // =========================================================
    // Reset-enable field
    // =========================================================
    logic [rst_strobe_pkg::RST_FIELD_W-1:0] field_reg;
    logic [rst_strobe_pkg::RST_FIELD_W-1:0] field_next;
    wire                                    reset_allowed;

    assign field_next = cfg_load.valid ? cfg_load.rst_field : field_reg;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            field_reg <= rst_strobe_pkg::RST_FIELD_RESET;
        end else begin
            field_reg <= field_next;
        end
    end

    assign reset_allowed = (field_reg == rst_strobe_pkg::RST_FIELD_ON);

    // =========================================================
    // Reset sequence state machine
    // =========================================================
    rst_strobe_pkg::seq_state_t state_reg;
    rst_strobe_pkg::seq_state_t state_next;
    logic [CNT_W-1:0]           cnt_reg;
    logic [CNT_W-1:0]           cnt_next;
    logic                       start_reg;
    wire                        accept_rise;
    wire                        cnt_done;

    assign accept_rise = pin_rise & reset_allowed
                       & (state_reg != rst_strobe_pkg::ST_WAIT_CFG);
    assign cnt_done    = (cnt_reg == CNT_W'(1));

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            rst_strobe_pkg::ST_WAIT_CFG: begin
                if (cfg_load.valid) begin
                    state_next = rst_strobe_pkg::ST_READY;
                end
            end
            rst_strobe_pkg::ST_READY: begin
                if (accept_rise) begin
                    state_next = rst_strobe_pkg::ST_SEQ;
                    cnt_next   = CNT_W'(SEQ_CYCLES);
                end
            end
            rst_strobe_pkg::ST_SEQ: begin
                // A fresh pulse during the sequence restarts it, as a
                // second reset must leave the device fully reset again.
                if (accept_rise) begin
                    cnt_next = CNT_W'(SEQ_CYCLES);
                end else if (cnt_done) begin
                    state_next = rst_strobe_pkg::ST_READY;
                    cnt_next   = '0;
                end else begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end
            end
            default: begin
                state_next = rst_strobe_pkg::ST_WAIT_CFG;
                cnt_next   = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= rst_strobe_pkg::ST_WAIT_CFG;
            cnt_reg   <= '0;
            start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            start_reg <= accept_rise;
        end
    end

    assign seq_start    = start_reg;
    assign cfg_loaded   = (state_reg != rst_strobe_pkg::ST_WAIT_CFG);
    // Core reset lasts as long as the window in which the host may not
    // yet send commands, but begins three clocks after the pin rises.
    // host delay window
    assign core_reset_b = (state_reg != rst_strobe_pkg::ST_SEQ);

    // =========================================================
    // Data strobe
    // =========================================================
    logic strobe_reg;
    logic strobe_next;
    wire  strobe_active;

    assign strobe_active = ddr_mode & (strobe_src.cmd_resp
                                     | strobe_src.read_data
                                     | strobe_src.crc_token);
    assign strobe_next   = strobe_active ? ~strobe_reg : 1'b0;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= strobe_next;
        end
    end

    // The strobe is driven low when idle in double-rate mode rather
    // than released, so the host never sees a floating edge.
    assign read_strobe_pin = strobe_reg;
    assign read_strobe_oe  = ddr_mode;

    // =========================================================
    // Assertions
    // =========================================================
    sequence resp_req_s;
        ddr_mode && strobe_src.cmd_resp;
    endsequence

    sequence rise_ok_s;
        pin_rise && reset_allowed && cfg_loaded;
    endsequence

    AST_RESP_STROBE: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        resp_req_s |=> (read_strobe_pin != $past(read_strobe_pin)))
        else $error("Strobe did not toggle with a command response.");

    AST_STROBE_IDLE: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !(ddr_mode && (strobe_src.read_data || strobe_src.crc_token
                       || strobe_src.cmd_resp))
        |=> !read_strobe_pin)
        else $error("Strobe moved outside response, data or token.");

    AST_RISE_START: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        rise_ok_s |=> seq_start ##1 !core_reset_b)
        else $error("Accepted rising edge did not start the sequence.");

    AST_NO_FALL_START: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        pin_fall |=> !seq_start)
        else $error("Sequence started on a falling edge.");

    AST_CFG_GATE: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        !cfg_loaded |=> !seq_start)
        else $error("Reset acted before the field was loaded.");

    AST_DISABLED: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (cfg_loaded && !reset_allowed) |=> !seq_start)
        else $error("Reset acted while the field forbids it.");

    AST_SEQ_HOLD: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        seq_start |=> !core_reset_b [*4])
        else $error("Core reset released too early.");

endmodule : hw_reset_and_strobe_control

// File: dv/host_model.sv
`timescale 1ns/1ps
module host_model #(
    parameter int GAP_CYC      = 40,
    // Reset release to the first command, in bus clocks.
    parameter int CMD_WAIT_CYC = rst_strobe_pkg::RESET_TO_CMD_CYC,
    // Bus clocks owed before the first identification command.
    parameter int INIT_CLK_CYC = 74
) (
    // Clock
    input  wire logic ref_clk,
    // Reset pin toward the device
    output logic      hw_reset_pin_b
);

    // The longer of the two waits covers both obligations at once.
    localparam int WAIT_CYC = (CMD_WAIT_CYC > INIT_CLK_CYC)
                            ? CMD_WAIT_CYC : INIT_CLK_CYC;

    initial hw_reset_pin_b = 1'b1;

    // =========================================================
    // Reset pulse
    // =========================================================
    // low width and high interval
    task automatic pulse();
        repeat (GAP_CYC) @(posedge ref_clk);
        #1 hw_reset_pin_b = 1'b0;
        repeat (GAP_CYC) @(posedge ref_clk);
        #1 hw_reset_pin_b = 1'b1;
    endtask : pulse

    // =========================================================
    // Command wait
    // =========================================================
    // command wait
    task automatic cmd_wait();
        repeat (WAIT_CYC) @(posedge ref_clk);
        #1;
    endtask : cmd_wait

endmodule : host_model

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;

    localparam int SEQ = 10;

    logic                        ref_clk;
    logic                        rst_b;
    logic                        hw_reset_pin_b;
    logic                        ddr_mode;
    logic                        read_strobe_pin;
    logic                        read_strobe_oe;
    logic                        cfg_loaded;
    logic                        seq_start;
    logic                        core_reset_b;
    rst_strobe_pkg::rst_cfg_t    cfg_load;
    rst_strobe_pkg::strobe_src_t strobe_src;
    int                          n_mismatch;
    int                          n_compared;
    int                          n_start;

    hw_reset_and_strobe_control #(.SEQ_CYCLES(SEQ)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .hw_reset_pin_b(hw_reset_pin_b),
        .cfg_load(cfg_load), .ddr_mode(ddr_mode), .strobe_src(strobe_src),
        .read_strobe_pin(read_strobe_pin), .read_strobe_oe(read_strobe_oe),
        .cfg_loaded(cfg_loaded), .seq_start(seq_start),
        .core_reset_b(core_reset_b)
    );

    host_model #(.CMD_WAIT_CYC(SEQ)) host (
        .ref_clk(ref_clk), .hw_reset_pin_b(hw_reset_pin_b)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Counted on the falling edge so the registered pulse has settled.
    always @(negedge ref_clk) begin
        if (seq_start === 1'b1) n_start++;
    end

    // =========================================================
    // Helpers
    // =========================================================
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    // =========================================================
    // Scenarios
    // =========================================================
    task automatic pulse_expect(input logic [1:0] f, input logic act);
        int s;
        int w;
        s = n_start;
        cfg_load = '{1'b1, f};
        step(1);
        cfg_load = '0;
        chk(8'(cfg_loaded), 8'h01);
        host.pulse();
        // The falling edge alone must not have started anything.
        chk(8'(n_start - s), 8'h00);
        w = 0;
        while (seq_start !== 1'b1 && w < 8) begin
            step(1);
            w++;
        end
        if (act && w == 8) begin
            n_mismatch++;
            end_of_test();
        end
        // Let the falling-edge counter see the pulse before comparing.
        step(1);
        chk(8'(n_start - s), 8'(act));
        if (act) begin
            // The core is held from the start pulse on, one cycle ago.
            w = 1;
            while (core_reset_b === 1'b0 && w < 40) begin
                step(1);
                w++;
            end
            chk(8'(w), 8'(SEQ));
            host.cmd_wait();
            chk(8'(core_reset_b), 8'h01);
        end
    endtask : pulse_expect

    task automatic strobe_check(input int i);
        logic [4:0] v;
        ddr_mode = 1'b1;
        strobe_src = 3'(1 << i);
        v = '0;
        repeat (3) begin
            step(1);
            v = {v[3:0], read_strobe_pin};
        end
        strobe_src = '0;
        repeat (2) begin
            step(1);
            v = {v[3:0], read_strobe_pin};
        end
        chk(8'(v), 8'h14);
        chk(8'(read_strobe_oe), 8'h01);
        ddr_mode = 1'b0;
        strobe_src = 3'(1 << i);
        step(2);
        chk(8'({read_strobe_pin, read_strobe_oe}), 8'h00);
        strobe_src = '0;
        // One edge passes so the next call does not rewrite the sources
        // in the same time step.
        step(1);
    endtask : strobe_check

    initial begin
        #2000000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        n_mismatch = 0;
        n_compared = 0;
        n_start = 0;
        rst_b = 1'b0;
        ddr_mode = 1'b0;
        cfg_load = '0;
        strobe_src = '0;
        step(12);
        chk(8'({read_strobe_pin, seq_start, cfg_loaded, core_reset_b}), 8'h01);
        rst_b = 1'b1;
        step(2);
        chk(8'(n_start), 8'h00);
        host.pulse();
        step(8);
        chk(8'(n_start), 8'h00);
        for (int f = 0; f < 4; f++) begin
            pulse_expect(2'(f), f == 1);
        end
        for (int i = 0; i < 3; i++) begin
            strobe_check(i);
        end
        end_of_test();
    end

endmodule : testbench
